// [hdl/swn_pkg.sv]
/*
 Shared constants, types and helper functions of the single-wire
 net-address link: timing counts, opcodes, address layout, CRC.
 Assumes one 20 MHz clock (50 ns period) in both ends.
*/
package swn_pkg;

   // ==========================================================
   // Clock and conversion helpers
   // ==========================================================
   localparam int CLK_NS = 50;

   // Least time in microseconds to cycles, rounded up
   function automatic int swn_us_up(input int us);
      return (us * 1000 + CLK_NS - 1) / CLK_NS;
   endfunction

   // Longest time in microseconds to cycles, rounded down
   function automatic int swn_us_dn(input int us);
      return (us * 1000) / CLK_NS;
   endfunction

   // ==========================================================
   // Device timing
   // ==========================================================
   localparam int T_RST_DET_US = 120;  // low longer than this is a reset
   localparam int T_SMP_US     = 30;   // write-slot sample point
   localparam int T_TXH_US     = 45;   // read-slot low hold for a zero
   localparam int T_PDH_US     = 30;   // presence-high delay
   localparam int T_PDL_US     = 100;  // presence-low duration
   localparam int RST_DET_CYC  = swn_us_up(T_RST_DET_US);
   localparam int SMP_CYC      = swn_us_up(T_SMP_US);
   localparam int TXH_CYC      = swn_us_dn(T_TXH_US);
   localparam int PDH_CYC      = swn_us_up(T_PDH_US);
   localparam int PDL_CYC      = swn_us_up(T_PDL_US);

   // ==========================================================
   // Host timing
   // ==========================================================
   localparam int T_W0_LOW_US  = 60;
   localparam int T_W1_LOW_US  = 5;
   localparam int T_RD_LOW_US  = 1;
   localparam int T_RDV_US     = 15;
   localparam int T_SLOT_US    = 70;
   localparam int T_REC_US     = 5;
   localparam int T_RSTL_US    = 480;
   localparam int T_RSTH_US    = 480;
   localparam int T_PRS_SMP_US = 60;   // presence sample after release
   localparam int W0_LOW_CYC   = swn_us_up(T_W0_LOW_US);
   localparam int W1_LOW_CYC   = swn_us_up(T_W1_LOW_US);
   localparam int RD_LOW_CYC   = swn_us_up(T_RD_LOW_US);
   localparam int RDV_CYC      = swn_us_dn(T_RDV_US);
   localparam int SLOT_CYC     = swn_us_up(T_SLOT_US + T_REC_US);
   localparam int PRS_SMP_CYC  = swn_us_up(T_PRS_SMP_US);

   // ==========================================================
   // Net address, opcodes, CRC
   // ==========================================================
   localparam int           ADDR_BITS   = 64;
   localparam int           BYTE_BITS   = 8;
   localparam int           SERIAL_BITS = 48;
   localparam logic [7:0]   OPC_RD_A    = 8'h33;
   localparam logic [7:0]   OPC_RD_B    = 8'h39;
   localparam logic [7:0]   OPC_MATCH   = 8'h55;
   localparam logic [7:0]   OPC_SKIP    = 8'hCC;
   localparam logic [7:0]   OPC_SEARCH  = 8'hF0;
   localparam logic [7:0]   OPC_RESUME  = 8'hA5;
   localparam logic [7:0]   CRC_POLY    = 8'h8C;  // x^8+x^5+x^4+1 reflected
   localparam logic [7:0]   CRC_INIT    = 8'h00;

   // One reflected CRC step, LSB-first input
   function automatic logic [7:0] swn_crc_step(input logic [7:0] crc,
                                               input logic       din);
      logic fb;
      fb = crc[0] ^ din;
      return fb ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
   endfunction

   // CRC over family code and serial number, 56 bits
   function automatic logic [7:0] swn_addr_crc(input logic [55:0] low56);
      logic [7:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 56; i++)
         c = swn_crc_step(c, low56[i]);
      return c;
   endfunction

   // ==========================================================
   // State and command types
   // ==========================================================
   typedef enum logic [7:0] {
      DS_WAIT = 8'h01,
      DS_PDH  = 8'h02,
      DS_PDL  = 8'h04,
      DS_ROM  = 8'h08,
      DS_RDA  = 8'h10,
      DS_MAT  = 8'h20,
      DS_SRC  = 8'h40,
      DS_FUN  = 8'h80
   } swn_dst_t;

   typedef enum logic [1:0] {
      HS_IDLE = 2'h1,
      HS_RUN  = 2'h2
   } swn_hst_t;

   typedef enum logic [1:0] {
      OP_RESET = 2'h0,
      OP_WRITE = 2'h1,
      OP_READ  = 2'h2
   } swn_op_t;

endpackage

// [hdl/swn_if.sv]
/*
 Single data line joining the addressing slave and the bus master.
 Both ends drive open-drain style; the line is the wired-AND of both.
*/
`timescale 1ns/1ns
interface swn_if;
   logic dq;        // resolved line level
   logic dev_o;     // device output value, always low
   logic dev_oe_n;  // device output enable, low drives
   logic host_o;
   logic host_oe_n;

   // Released drivers read as pulled high
   assign dq = (dev_oe_n | dev_o) & (host_oe_n | host_o);

   modport dev  (input dq, output dev_o, output dev_oe_n);
   modport host (input dq, output host_o, output host_oe_n);
endinterface

// [hdl/swn_dev.sv]
/*
 Net-address slave end of the single-wire link: reset/presence,
 bit slots, read/match/skip/search/resume address commands and the
 capture of the following function command byte.
 Assumes the line input is synchronous to ref_clk and a pull-up.
*/
// What the link requires
// RQ1: Power-switch low wakes sleeping device only
// RQ2: Fixed 64-bit address, family, serial, CRC
// RQ3: Top address byte is CRC of 56
// RQ4: Master CRC checks start zero, LSB first
// RQ5: CRC polynomial x^8+x^5+x^4+1, reflected
// RQ6: Device never checks CRC nor aborts
// RQ7: Device only pulls line low, open-drain
// RQ8: Master leaves line high while paused
// RQ9: Low beyond 120us is a reset
// RQ10: Order: init, address, function, data
// RQ11: Reset pulse answered by presence pulse
// RQ12: Read address opcode 33h or 39h
// RQ13: Read address only with single slave
// RQ14: Match 55h: only matching device proceeds
// RQ15: Skip CCh goes straight to function
// RQ16: Search F0h: bit, complement, master bit
// RQ17: Search loser stays silent until reset
// RQ18: Resume A5h acts as skip if flagged
// RQ19: Resume flag set by match or search
// RQ20: Resume flag cleared when another selected
// RQ21: All transfers least significant bit first
// RQ22: Write slot sampled 15us to 60us
// RQ23: Master read slot low 1us, sample 15us
// RQ24: Presence after high delay, low duration
`timescale 1ns/1ns
module swn_dev
#(
   parameter logic [7:0]  FAMILY_CODE = 8'h5A,          // arbitrary value
   parameter logic [47:0] SERIAL_NUM  = 48'h0000_1234_ABCD  // arbitrary value
)
(
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst_b,
   // Single-wire line
   swn_if.dev                 bus,
   // Power and mode
   input  wire logic          power_switch_wake_n,
   input  wire logic          sleep_req,
   input  wire logic          addr_read_opcode_select,
   // Status and function command
   output logic               active,
   output logic               resume_flag,
   output logic               func_valid,
   output logic [7:0]         func_cmd
);
   import swn_pkg::*;

   // ==========================================================
   // Net address
   // ==========================================================
   localparam logic [55:0]          ADDR_LOW = {SERIAL_NUM, FAMILY_CODE};
   localparam logic [ADDR_BITS-1:0] NET_ADDR = {swn_addr_crc(ADDR_LOW), ADDR_LOW}; // RQ2 RQ3 RQ5

   localparam logic [11:0] RST_C  = 12'(RST_DET_CYC);
   localparam logic [11:0] SMP_C  = 12'(SMP_CYC);
   localparam logic [11:0] TXH_C  = 12'(TXH_CYC);
   localparam logic [11:0] PDH_C  = 12'(PDH_CYC);
   localparam logic [11:0] PDL_C  = 12'(PDL_CYC);
   localparam logic [6:0]  LAST_A = 7'(ADDR_BITS - 1);
   localparam logic [6:0]  LAST_B = 7'(BYTE_BITS - 1);
   localparam logic [1:0]  PH_BIT = 2'h0;
   localparam logic [1:0]  PH_CMP = 2'h1;
   localparam logic [1:0]  PH_WR  = 2'h2;

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      swn_dst_t    st;
      logic        awake;
      logic        oe_n;
      logic        dq_prev;
      logic [11:0] low_cnt;
      logic        rst_seen;
      logic [11:0] tmr;
      logic        slot_on;
      logic [6:0]  bit_cnt;
      logic [1:0]  ph;
      logic        mis;
      logic [7:0]  sh;
      logic        resume;
      logic        fvalid;
      logic [7:0]  fcmd;
   } swn_dev_st_t;

   swn_dev_st_t r_q;
   swn_dev_st_t r_d;

   logic [5:0] idx;
   logic       my_bit;
   logic       tx_st;
   logic       tx_bit;
   logic       fall;
   logic       rise;
   logic       bit_done;
   logic [7:0] byte_in;
   logic [7:0] rd_opc;

   // ==========================================================
   // Next-state logic
   // ==========================================================
   always_comb
   begin
      r_d      = r_q;
      r_d.fvalid = 1'b0;
      r_d.dq_prev = bus.dq;
      idx      = r_q.bit_cnt[5:0];
      my_bit   = NET_ADDR[idx];
      fall     = r_q.dq_prev & ~bus.dq;
      rise     = ~r_q.dq_prev & bus.dq;
      byte_in  = {bus.dq, r_q.sh[7:1]};                 // RQ21
      rd_opc   = addr_read_opcode_select ? OPC_RD_B : OPC_RD_A; // RQ12
      bit_done = 1'b0;
      // Slots in which the device transmits, and the bit it sends
      tx_st    = (r_q.st == DS_RDA) || ((r_q.st == DS_SRC) && (r_q.ph != PH_WR));
      tx_bit   = ((r_q.st == DS_SRC) && (r_q.ph == PH_CMP)) ? ~my_bit : my_bit; // RQ16

      if (!r_q.awake)
      begin
         // Wake only from sleep; active ignores the input
         if (!power_switch_wake_n)
            r_d.awake = 1'b1;                           // RQ1
         r_d.oe_n = 1'b1;
      end
      else if (sleep_req)
      begin
         r_d.awake   = 1'b0;
         r_d.oe_n    = 1'b1;
         r_d.st      = DS_WAIT;
         r_d.slot_on = 1'b0;
      end
      else
      begin
         // Bit slot engine, started by a master falling edge
         if (r_q.slot_on)
         begin
            r_d.tmr = r_q.tmr + 12'h001;
            if (r_q.tmr == SMP_C)
               bit_done = 1'b1;                         // RQ22
            if (r_q.tmr == TXH_C)
            begin
               r_d.slot_on = 1'b0;
               r_d.oe_n    = 1'b1;
            end
         end
         else if (fall && (r_q.st inside {DS_ROM, DS_RDA, DS_MAT, DS_SRC, DS_FUN}))
         begin
            r_d.slot_on = 1'b1;
            r_d.tmr     = 12'h000;
            if (tx_st && !tx_bit)
               r_d.oe_n = 1'b0;                         // RQ7
         end

         // Command sequencing
         case (r_q.st)
            DS_PDH:
            begin
               r_d.tmr = r_q.tmr + 12'h001;
               if (r_q.tmr == PDH_C)
               begin
                  r_d.st   = DS_PDL;
                  r_d.tmr  = 12'h000;
                  r_d.oe_n = 1'b0;                      // RQ11 RQ24
               end
            end
            DS_PDL:
            begin
               r_d.tmr = r_q.tmr + 12'h001;
               if (r_q.tmr == PDL_C)
               begin
                  r_d.st      = DS_ROM;                 // RQ10
                  r_d.oe_n    = 1'b1;
                  r_d.bit_cnt = 7'h00;
               end
            end
            DS_ROM:
               if (bit_done)
               begin
                  r_d.sh      = byte_in;
                  r_d.bit_cnt = r_q.bit_cnt + 7'h01;
                  if (r_q.bit_cnt == LAST_B)
                  begin
                     r_d.bit_cnt = 7'h00;
                     r_d.ph      = PH_BIT;
                     r_d.mis     = 1'b0;
                     if (byte_in == rd_opc)
                        r_d.st = DS_RDA;                // RQ12
                     else if (byte_in == OPC_MATCH)
                        r_d.st = DS_MAT;                // RQ14
                     else if (byte_in == OPC_SKIP)
                        r_d.st = DS_FUN;                // RQ15
                     else if (byte_in == OPC_SEARCH)
                        r_d.st = DS_SRC;                // RQ16
                     else if (byte_in == OPC_RESUME && r_q.resume)
                        r_d.st = DS_FUN;                // RQ18
                     else
                        r_d.st = DS_WAIT;
                  end
               end
            DS_RDA:
               if (bit_done)
               begin
                  r_d.bit_cnt = r_q.bit_cnt + 7'h01;
                  if (r_q.bit_cnt == LAST_A)
                  begin
                     r_d.bit_cnt = 7'h00;
                     r_d.st      = DS_FUN;              // RQ6
                  end
               end
            DS_MAT:
               if (bit_done)
               begin
                  r_d.bit_cnt = r_q.bit_cnt + 7'h01;
                  if (bus.dq != my_bit)
                     r_d.mis = 1'b1;
                  if (r_q.bit_cnt == LAST_A)
                  begin
                     r_d.bit_cnt = 7'h00;
                     if (r_q.mis || (bus.dq != my_bit))
                     begin
                        r_d.resume = 1'b0;              // RQ20
                        r_d.st     = DS_WAIT;           // RQ14
                     end
                     else
                     begin
                        r_d.resume = 1'b1;              // RQ19
                        r_d.st     = DS_FUN;
                     end
                  end
               end
            DS_SRC:
               if (bit_done)
               begin
                  if (r_q.ph == PH_BIT)
                     r_d.ph = PH_CMP;
                  else if (r_q.ph == PH_CMP)
                     r_d.ph = PH_WR;
                  else if (bus.dq != my_bit)
                  begin
                     r_d.resume = 1'b0;                 // RQ20
                     r_d.st     = DS_WAIT;              // RQ17
                  end
                  else
                  begin
                     r_d.ph      = PH_BIT;
                     r_d.bit_cnt = r_q.bit_cnt + 7'h01;
                     if (r_q.bit_cnt == LAST_A)
                     begin
                        r_d.bit_cnt = 7'h00;
                        r_d.resume  = 1'b1;             // RQ19
                        r_d.st      = DS_FUN;
                     end
                  end
               end
            DS_FUN:
               if (bit_done)
               begin
                  r_d.sh      = byte_in;
                  r_d.bit_cnt = r_q.bit_cnt + 7'h01;
                  if (r_q.bit_cnt == LAST_B)
                  begin
                     r_d.fcmd   = byte_in;              // RQ10
                     r_d.fvalid = 1'b1;
                     r_d.st     = DS_WAIT;
                  end
               end
            DS_WAIT:
               r_d.tmr = 12'h000;
            default:
               r_d.st = DS_WAIT;
         endcase

         // Reset pulse detection overrides everything
         if (!bus.dq)
         begin
            if (r_q.low_cnt != RST_C)
               r_d.low_cnt = r_q.low_cnt + 12'h001;
            else
            begin
               r_d.rst_seen = 1'b1;                     // RQ9
               r_d.st       = DS_WAIT;
               r_d.slot_on  = 1'b0;
               r_d.oe_n     = 1'b1;
            end
         end
         else
            r_d.low_cnt = 12'h000;
         if (rise && r_q.rst_seen)
         begin
            r_d.rst_seen = 1'b0;
            r_d.st       = DS_PDH;                      // RQ24
            r_d.tmr      = 12'h000;
         end
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r_q        <= '0;
         r_q.st     <= DS_WAIT;
         r_q.oe_n   <= 1'b1;
         r_q.dq_prev <= 1'b1;
      end
      else
         r_q <= r_d;
   end

   // Outputs straight from state; the line is only ever pulled low
   assign bus.dev_o    = 1'b0;                          // RQ7
   assign bus.dev_oe_n = r_q.oe_n;
   assign active       = r_q.awake;
   assign resume_flag  = r_q.resume;
   assign func_valid   = r_q.fvalid;
   assign func_cmd     = r_q.fcmd;

endmodule

// [hdl/swn_host.sv]
/*
 Bus master end of the single-wire link: reset with presence
 sampling, write and read bit slots, and a CRC accumulator for
 checking the slave's net address.
 Assumes the line input is synchronous to ref_clk and a pull-up.
*/
`timescale 1ns/1ns
module swn_host
#(
   parameter int RST_LOW_CYC  = swn_pkg::swn_us_up(swn_pkg::T_RSTL_US),
   parameter int RST_HIGH_CYC = swn_pkg::swn_us_up(swn_pkg::T_RSTH_US)
)
(
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst_b,
   // Single-wire line
   swn_if.host                bus,
   // Command port
   input  wire logic          cmd_valid,
   input  swn_pkg::swn_op_t   cmd_op,
   input  wire logic          cmd_bit,
   input  wire logic          crc_clear,
   // Results
   output logic               busy,
   output logic               done,
   output logic               rd_bit,
   output logic               presence,
   output logic [7:0]         crc
);
   import swn_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      swn_hst_t    st;
      swn_op_t     op;
      logic        wbit;
      logic [15:0] cnt;
      logic        oe_n;
      logic        busy;
      logic        done;
      logic        rbit;
      logic        pres;
      logic [7:0]  crc;
   } swn_host_st_t;

   swn_host_st_t r_q;
   swn_host_st_t r_d;
   logic [15:0]  lo_len;
   logic [15:0]  smp;
   logic [15:0]  tot;

   // ==========================================================
   // Slot shape per operation
   // ==========================================================
   always_comb
   begin
      case (r_q.op)
         OP_RESET:
         begin
            lo_len = 16'(RST_LOW_CYC);
            smp    = 16'(RST_LOW_CYC + PRS_SMP_CYC);
            tot    = 16'(RST_LOW_CYC + RST_HIGH_CYC);
         end
         OP_WRITE:
         begin
            lo_len = r_q.wbit ? 16'(W1_LOW_CYC) : 16'(W0_LOW_CYC);
            smp    = 16'(SLOT_CYC);
            tot    = 16'(SLOT_CYC);
         end
         default:
         begin
            lo_len = 16'(RD_LOW_CYC);                   // RQ23
            smp    = 16'(RDV_CYC);                      // RQ23
            tot    = 16'(SLOT_CYC);
         end
      endcase
   end

   // ==========================================================
   // Next-state logic
   // ==========================================================
   always_comb
   begin
      r_d      = r_q;
      r_d.done = 1'b0;
      case (r_q.st)
         HS_IDLE:
         begin
            r_d.oe_n = 1'b1;                            // RQ8
            if (crc_clear)
               r_d.crc = CRC_INIT;                      // RQ4
            if (cmd_valid)
            begin
               r_d.st   = HS_RUN;
               r_d.op   = cmd_op;
               r_d.wbit = cmd_bit;
               r_d.cnt  = 16'h0000;
               r_d.oe_n = 1'b0;
               r_d.busy = 1'b1;
            end
         end
         HS_RUN:
         begin
            r_d.cnt = r_q.cnt + 16'h0001;
            if (r_q.cnt == lo_len - 16'h0001)
               r_d.oe_n = 1'b1;
            if (r_q.cnt == smp)
            begin
               if (r_q.op == OP_RESET)
                  r_d.pres = ~bus.dq;                   // RQ11
               else if (r_q.op == OP_READ)
               begin
                  r_d.rbit = bus.dq;
                  r_d.crc  = swn_crc_step(r_q.crc, bus.dq); // RQ4 RQ5 RQ21
               end
               else
                  r_d.crc  = swn_crc_step(r_q.crc, r_q.wbit);
            end
            if (r_q.cnt == tot)
            begin
               r_d.st   = HS_IDLE;
               r_d.busy = 1'b0;
               r_d.done = 1'b1;
            end
         end
         default:
            r_d.st = HS_IDLE;
      endcase
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r_q      <= '0;
         r_q.st   <= HS_IDLE;
         r_q.oe_n <= 1'b1;
         r_q.crc  <= CRC_INIT;
      end
      else
         r_q <= r_d;
   end

   assign bus.host_o    = 1'b0;
   assign bus.host_oe_n = r_q.oe_n;
   assign busy          = r_q.busy;
   assign done          = r_q.done;
   assign rd_bit        = r_q.rbit;
   assign presence      = r_q.pres;
   assign crc           = r_q.crc;

endmodule

// [bench/swn_checker.sv]
/* Wire checker of the single-wire link.
   Takes the interface signals; one clock, async low reset. */
`timescale 1ns/1ns
module swn_checker
#(
   parameter int RST_LOW = 3000
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Line and drivers
   input wire logic dq,
   input wire logic dev_o,
   input wire logic dev_oe_n,
   input wire logic host_o,
   input wire logic host_oe_n
);
   logic [15:0] hlo_q, hhi_q, dlo_q;

   // ==========================================
   // Run lengths of host low, host high and device low
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hlo_q <= 16'h0000;
         hhi_q <= 16'h0000;
         dlo_q <= 16'h0000;
      end
      else
      begin
         hlo_q <= host_oe_n ? 16'h0000 : hlo_q + 16'h0001;
         hhi_q <= host_oe_n ? hhi_q + 16'h0001 : 16'h0000;
         dlo_q <= dev_oe_n ? 16'h0000 : dlo_q + 16'h0001;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // ==========================================
   // Wire rules
   a_dev_drive_low: assert property (dev_o == 1'b0)
      else $error("device drives high");
   a_host_drive_low: assert property (host_o == 1'b0)
      else $error("host drives high");
   a_presence_delay: assert property ($fell(dev_oe_n) && host_oe_n |->
      hhi_q inside {[598:606]}) else $error("presence delay wrong");
   a_drive_width: assert property ($rose(dev_oe_n) |->
      dlo_q inside {[897:906], [1999:2003]}) else $error("device low width wrong");
   a_zero_holds: assert property ($fell(dev_oe_n) && !host_oe_n |=> !dq [*8])
      else $error("zero bit not held");
   a_reset_quiet: assert property (hlo_q == 16'h09C4 |-> dev_oe_n)
      else $error("device drives in reset");
   a_host_width: assert property ($rose(host_oe_n) |->
      hlo_q inside {[18:22], [98:102], [1198:1202], [RST_LOW-2:RST_LOW+2]})
      else $error("host low width wrong");
   a_slot_gap: assert property ($fell(host_oe_n) |-> hhi_q >= 16'h0122)
      else $error("slot gap short");

   // Main scenarios
   c_presence: cover property ($fell(dev_oe_n) && host_oe_n);
   c_read_zero: cover property ($fell(dev_oe_n) && !host_oe_n);
   c_host_reset: cover property ($rose(host_oe_n) && hlo_q > 16'h0961);
endmodule

// [bench/swn_bench.sv]
/* Bench: host end talks to the device end over the link.
   Assumes package, interface and both ends compiled first. */
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module swn_bench;
   import swn_pkg::*;
   localparam logic [55:0] LOW = {48'h0000_1234_ABCD, 8'h5A};
   logic        ref_clk, rst_b, cmd_valid, cmd_bit, crc_clear, busy, done, rd_bit;
   logic        presence, wake_n, sleep_req, sel, active, resume_flag, func_valid;
   swn_op_t     cmd_op;
   logic [7:0]  crc, func_cmd;
   logic [63:0] addr, v;
   int          err_total, tests_run, i, k, lose, fv_cnt;

   swn_if link();
   swn_dev #(.FAMILY_CODE(LOW[7:0]), .SERIAL_NUM(LOW[55:8])) swn_dev_inst (.ref_clk,
      .rst_b, .bus(link.dev), .power_switch_wake_n(wake_n), .sleep_req,
      .addr_read_opcode_select(sel), .active, .resume_flag, .func_valid, .func_cmd);
   swn_host #(.RST_LOW_CYC(3000), .RST_HIGH_CYC(3000)) swn_host_inst (.ref_clk, .rst_b,
      .bus(link.host), .cmd_valid, .cmd_op, .cmd_bit, .crc_clear, .busy, .done,
      .rd_bit, .presence, .crc);
   swn_checker #(.RST_LOW(3000)) swn_checker_inst (.ref_clk, .rst_b, .dq(link.dq),
      .dev_o(link.dev_o), .dev_oe_n(link.dev_oe_n), .host_o(link.host_o),
      .host_oe_n(link.host_oe_n));

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Function-command strobes seen
   always @(posedge ref_clk)
      fv_cnt <= fv_cnt + int'(func_valid);

   // Reflected CRC over the low 56 address bits
   function automatic logic [7:0] crc56(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int j = 0; j < 56; j++)
         c = (c >> 1) ^ ((c[0] ^ d[j]) ? 8'h8C : 8'h00);
      return c;
   endfunction

   task automatic final_report();
      if (err_total == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One host command, bounded wait for done
   task automatic op(input swn_op_t o, input logic b);
      int n;
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_op = o;
      cmd_bit = b;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      `CHK(busy, 1'b1)
      for (n = 0; n < 20000 && done !== 1'b1; n++)
         @(posedge ref_clk) #1;
      if (n == 20000)
      begin
         err_total++;
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] b);
      for (int j = 0; j < 8; j++)
         op(OP_WRITE, b[j]);
   endtask

   task automatic rd(input int n);
      v = '1;
      for (int j = 0; j < n; j++)
      begin
         op(OP_READ, 1'b0);
         v[j] = rd_bit;
      end
   endtask

   // Reset, presence, then net-address opcode
   task automatic start(input logic [7:0] o);
      op(OP_RESET, 1'b0);
      `CHK(presence, 1'b1)
      wr(o);
   endtask

   // Function byte, checked as taken or ignored
   task automatic fbyte(input logic take);
      logic [7:0] o, f;
      int         c;
      o = func_cmd;
      c = fv_cnt;
      f = o ^ (8'($urandom) | 8'h01);
      wr(f);
      `CHK(func_cmd, take ? f : o)
      `CHK(fv_cnt - c, int'(take))
   endtask

   initial
   begin
      {cmd_valid, cmd_bit, crc_clear, sleep_req, sel, rst_b} = '0;
      cmd_op = OP_RESET;
      wake_n = 1'b1;
      void'($urandom(11625));
      addr = {crc56(LOW), LOW};
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (300) @(negedge ref_clk);
      // Asleep device is silent until woken
      op(OP_RESET, 1'b0);
      `CHK(presence, 1'b0)
      @(negedge ref_clk);
      wake_n = 1'b0;
      @(negedge ref_clk);
      wake_n = 1'b1;
      @(negedge ref_clk);
      `CHK(active, 1'b1)
      // Read address: other opcode refused, selected one answered
      sel = 1'($urandom);
      start(sel ? OPC_RD_A : OPC_RD_B);
      rd(8);
      `CHK(v[7:0], 8'hFF)
      start(sel ? OPC_RD_B : OPC_RD_A);
      @(negedge ref_clk);
      crc_clear = 1'b1;
      @(negedge ref_clk);
      crc_clear = 1'b0;
      rd(64);
      `CHK(v, addr)
      `CHK(crc, 8'h00)
      fbyte(1'b1);
      // Match with one flipped bit, then exact
      for (k = 0; k < 2; k++)
      begin
         v = addr;
         i = $urandom_range(63, 0);
         v[i] = v[i] ^ (k == 0);
         start(OPC_MATCH);
         for (i = 0; i < 64; i++)
            op(OP_WRITE, v[i]);
         fbyte(k == 1);
         `CHK(resume_flag, k == 1)
         start(OPC_RESUME);
         fbyte(k == 1);
      end
      start(OPC_RESUME);
      fbyte(1'b1);
      start(OPC_SKIP);
      fbyte(1'b1);
      // Search: bit and complement, then the device loses
      lose = $urandom_range(7, 0);
      start(OPC_SEARCH);
      for (i = 0; i <= lose; i++)
      begin
         rd(2);
         `CHK(v[1:0], {~addr[i], addr[i]})
         op(OP_WRITE, addr[i] ^ (i == lose));
      end
      rd(2);
      `CHK(v[1:0], 2'b11)
      `CHK(resume_flag, 1'b0)
      // Sleep request silences the device
      @(negedge ref_clk);
      sleep_req = 1'b1;
      @(negedge ref_clk);
      sleep_req = 1'b0;
      op(OP_RESET, 1'b0);
      `CHK(presence, 1'b0)
      final_report();
   end
endmodule
